// ---- pkg/rat_pkg.sv ----
package rat_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned T_SEC_MS = 1000;
  localparam int unsigned T_HOLD_MS = 500;
  localparam int unsigned SEC_CYCLES_DEF = CLK_HZ / 1000 * T_SEC_MS;
  localparam int unsigned HOLD_CYCLES_DEF = CLK_HZ / 1000 * T_HOLD_MS;
  // ==========================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_WAKE_SEC = 8'h46;
  localparam logic [7:0] IDX_WAKE_MIN = 8'h47;
  localparam logic [7:0] IDX_WAKE_HOUR = 8'h48;
  localparam logic [7:0] IDX_WAKE_DAY = 8'h49;
  localparam logic [7:0] IDX_WAKE_MONTH = 8'h4a;
  localparam logic [7:0] IDX_WAKE_YEAR = 8'h4b;
  localparam logic [7:0] IDX_ELAPSED0 = 8'h4c;
  localparam logic [7:0] IDX_ELAPSED1 = 8'h4d;
  localparam logic [7:0] IDX_ELAPSED2 = 8'h4e;
  localparam logic [7:0] IDX_ELAPSED3 = 8'h4f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'ha0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'ha1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'ha2;
  // ==========================================
  // field positions
  localparam int unsigned POS_TICK_WAKE = 5;
  localparam int unsigned POS_TICK_MIN = 4;
  localparam int unsigned POS_TICK_ON = 7;
  localparam int unsigned POS_ALARM_ON = 6;
  localparam int unsigned POS_CAUSE = 6;
  localparam int unsigned EV_TICK = 0;
  localparam int unsigned EV_ALARM = 1;
  localparam int unsigned NUM_EV = 2;
  // ==========================================
  // reset values
  localparam logic [5:0] RST_SEC = 6'h00;
  localparam logic [5:0] RST_MIN = 6'h00;
  localparam logic [4:0] RST_HOUR = 5'h00;
  localparam logic [4:0] RST_DAY = 5'h01;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [5:0] RST_YEAR = 6'h00;
  // calendar limits
  localparam logic [5:0] MAX_SEC = 6'h3b;
  localparam logic [4:0] MAX_HOUR = 5'h17;
  localparam logic [3:0] MAX_MONTH = 4'hc;
  // ==========================================
  // bus data phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } rat_phase_e;
endpackage

// ---- logic/rat_calendar.sv ----
// ==========================================
// one-second prescaler, calendar and elapsed seconds
module rat_calendar import rat_pkg::*; #(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  output logic o_sec_stb,
  output logic [5:0] o_sec,
  output logic [5:0] o_min,
  output logic [4:0] o_hour,
  output logic [4:0] o_day,
  output logic [3:0] o_mon,
  output logic [5:0] o_year,
  output logic [31:0] o_count
);
  logic [31:0] pre;
  logic wrap;
  logic [4:0] last_day;

  assign wrap = (pre == SEC_CYCLES - 1);

  // month length, leap year every fourth year from 2000
  always_comb begin
    unique case (o_mon)
      4'h2: last_day = (o_year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: last_day = 5'h1e;
      default: last_day = 5'h1f;
    endcase
  end

  // prescaler, strobe comes with the new calendar values
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre <= 32'h0;
      o_sec_stb <= 1'b0;
    end else if (i_ce) begin
      pre <= wrap ? 32'h0 : pre + 32'h1;
      o_sec_stb <= wrap;
    end
  end

  // cascaded calendar counters
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sec <= RST_SEC;
      o_min <= RST_MIN;
      o_hour <= RST_HOUR;
      o_day <= RST_DAY;
      o_mon <= RST_MONTH;
      o_year <= RST_YEAR;
      o_count <= 32'h0;
    end else if (i_ce && wrap) begin
      o_count <= o_count + 32'h1;
      o_sec <= (o_sec == MAX_SEC) ? 6'h0 : o_sec + 6'h1;
      if (o_sec == MAX_SEC) begin
        o_min <= (o_min == MAX_SEC) ? 6'h0 : o_min + 6'h1;
        if (o_min == MAX_SEC) begin
          o_hour <= (o_hour == MAX_HOUR) ? 5'h0 : o_hour + 5'h1;
          if (o_hour == MAX_HOUR) begin
            o_day <= (o_day == last_day) ? RST_DAY : o_day + 5'h1;
            if (o_day == last_day) begin
              o_mon <= (o_mon == MAX_MONTH) ? RST_MONTH : o_mon + 4'h1;
              if (o_mon == MAX_MONTH) begin
                o_year <= o_year + 6'h1; // wraps after 63
              end
            end
          end
        end
      end
    end
  end
endmodule // rat_calendar

// ---- logic/rat_events.sv ----
// ==========================================
// tick and calendar match detection
module rat_events import rat_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_sec_stb,
  input wire logic [5:0] i_sec,
  input wire logic [5:0] i_min,
  input wire logic [4:0] i_hour,
  input wire logic [4:0] i_day,
  input wire logic [3:0] i_mon,
  input wire logic [5:0] i_year,
  input wire logic [5:0] i_w_sec,
  input wire logic [5:0] i_w_min,
  input wire logic [4:0] i_w_hour,
  input wire logic [4:0] i_w_day,
  input wire logic [3:0] i_w_mon,
  input wire logic [5:0] i_w_year,
  input wire logic i_tick_on,
  input wire logic i_tick_min,
  input wire logic i_alarm_on,
  output logic o_tick_ev,
  output logic o_alarm_ev
);
  logic match;

  assign match = (i_sec == i_w_sec) && (i_min == i_w_min) && (i_hour == i_w_hour)
    && (i_day == i_w_day) && (i_mon == i_w_mon) && (i_year == i_w_year);

  // only checked on a new second, so a match fires once, not for a whole second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tick_ev <= 1'b0;
      o_alarm_ev <= 1'b0;
    end else if (i_ce) begin
      o_tick_ev <= i_sec_stb && i_tick_on && (!i_tick_min || i_sec == 6'h0);
      o_alarm_ev <= i_sec_stb && i_alarm_on && match;
    end
  end
endmodule // rat_events

// ---- logic/rat_top.sv ----
// Function
// - wake hour setting, 5 bits at 4:0, range 0 to 23, upper bits read zero.
// - wake day setting, 5 bits at 4:0, range 1 to 31, bits 7:5 read zero.
// - month register bit 5 enables wake-up on the periodic tick.
// - month register bit 4 picks tick interval, 0 second, 1 minute.
// - wake month setting, 4 bits at 3:0, range 1 to 12, bits 7:6 zero.
// - year register bit 7 enables periodic tick events.
// - year register bit 6 enables the calendar match alarm.
// - wake year setting, 6 bits at 5:0, zero meaning year 2000.
// - writing the year register moves staged minute to month and the written year into active compare.
// - reading elapsed byte 0 captures all 32 bits, held about half a second.
// - elapsed seconds in four read-only bytes, least significant first.
// - seconds alarm bits 7:6 report cause: none, tick, alarm, both.
// - wake second and wake minute, 6 bits at 5:0, range 0 to 59.

// register page: byte address is four times the index, data in bits 7:0.
// reads see one wait state so their data always come from a flop;
// writes complete in their single data cycle with no wait.
// wake minute to month settings are staged and only a year write makes
// them live, so software can rewrite an alarm without a false match between.
// the interrupt status bits double as the cause field of the wake second register.
// hsize is ignored: each register is one aligned word with data in bits 7:0.
// only one interrupt output: high while any enabled status bit is set.
module rat_top import rat_pkg::*; #(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF,
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_CLK_EN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic O_IRQ,
  output logic O_WAKE
);
  // ==========================================
  // declarations
  rat_phase_e phase;
  logic [7:0] dph_idx;
  logic dph_map;
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [7:0] wd;
  logic [31:0] next_rdata;

  // per-register strobes, decoded once for all consumers
  logic wr_year;
  logic wr_clear;
  logic wr_enable;
  logic rd_first;
  logic [1:0] cause;

  // wake settings: second is live, minute to month are staged
  logic [5:0] w_sec;
  logic [5:0] stg_min;
  logic [4:0] stg_hour;
  logic [4:0] stg_day;
  logic [3:0] stg_mon;
  logic [5:0] act_min;
  logic [4:0] act_hour;
  logic [4:0] act_day;
  logic [3:0] act_mon;
  logic [5:0] act_year;
  logic tick_wake;
  logic tick_min;
  logic tick_on;
  logic alarm_on;

  // elapsed seconds snapshot
  logic [31:0] snap;
  logic [31:0] hold_cnt;
  logic holding;

  // calendar and events
  logic sec_stb;
  logic [5:0] c_sec;
  logic [5:0] c_min;
  logic [4:0] c_hour;
  logic [4:0] c_day;
  logic [3:0] c_mon;
  logic [5:0] c_year;
  logic [31:0] live;
  logic tick_ev;
  logic alarm_ev;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_enable;
  logic [NUM_EV-1:0] irq_clr;

  // ==========================================
  // ahb-lite slave front end
  // the only slave, so I_HREADY mirrors our own ready
  assign accept = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign wr_en = (phase == PH_WRITE) && dph_map;
  assign rd_en = (phase == PH_READ) && dph_map;
  assign wd = I_HWDATA[7:0];

  // one decode per register access; every consumer below shares the
  // same data-phase qualification, so none can act on a stale phase
  assign wr_year = wr_en && (dph_idx == IDX_WAKE_YEAR);
  assign wr_clear = wr_en && (dph_idx == IDX_IRQ_CLEAR);
  assign wr_enable = wr_en && (dph_idx == IDX_IRQ_ENABLE);
  assign rd_first = rd_en && (dph_idx == IDX_ELAPSED0);

  // data phase tracking; reads get one wait state so a
  // write just before them is always seen
  // a write to an unmapped or misaligned address is dropped through dph_map
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      phase <= PH_IDLE;
      dph_idx <= 8'h00;
      dph_map <= 1'b0;
    end else if (I_CLK_EN) begin
      if (accept) begin
        phase <= I_HWRITE ? PH_WRITE : PH_READ;
        dph_idx <= I_HADDR[9:2];
        dph_map <= (I_HADDR[31:10] == 22'h0) && (I_HADDR[1:0] == 2'h0);
      end else begin
        phase <= PH_IDLE;
      end
    end
  end

  // ready low only for the read wait cycle; response always okay
  // registered so the ready output never ripples from the bus inputs
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else if (I_CLK_EN) begin
      O_HREADYOUT <= !(accept && !I_HWRITE);
      O_HRESP <= 1'b0;
    end
  end

  // ==========================================
  // wake setting registers
  // the month tick bits act at once; only the alarm compare fields are staged
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      w_sec <= RST_SEC;
      stg_min <= RST_MIN;
      stg_hour <= RST_HOUR;
      stg_day <= RST_DAY;
      stg_mon <= RST_MONTH;
      tick_wake <= 1'b0;
      tick_min <= 1'b0;
    end else if (I_CLK_EN && wr_en) begin
      unique case (dph_idx)
        IDX_WAKE_SEC: w_sec <= wd[5:0];
        IDX_WAKE_MIN: stg_min <= wd[5:0];
        IDX_WAKE_HOUR: stg_hour <= wd[4:0];
        IDX_WAKE_DAY: stg_day <= wd[4:0];
        IDX_WAKE_MONTH: begin
          stg_mon <= wd[3:0];
          tick_wake <= wd[POS_TICK_WAKE];
          tick_min <= wd[POS_TICK_MIN];
        end
        default: ;
      endcase
    end
  end

  // year write commits the staged fields together, so the
  // comparator never sees minute to year half updated
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      act_min <= RST_MIN;
      act_hour <= RST_HOUR;
      act_day <= RST_DAY;
      act_mon <= RST_MONTH;
      act_year <= RST_YEAR;
      tick_on <= 1'b0;
      alarm_on <= 1'b0;
    end else if (I_CLK_EN && wr_year) begin
      act_min <= stg_min;
      act_hour <= stg_hour;
      act_day <= stg_day;
      act_mon <= stg_mon;
      act_year <= wd[5:0];
      tick_on <= wd[POS_TICK_ON];
      alarm_on <= wd[POS_ALARM_ON];
    end
  end

  // ==========================================
  // elapsed seconds snapshot
  assign holding = (hold_cnt != 32'h0);

  // a byte 0 read freezes the count; between holds the
  // snapshot follows the live counter
  // limitation: a second byte 0 read inside the hold recaptures and
  // restarts it, and a reader slower than the hold still mixes bytes of two counts
  // the hold counts clock cycles, not seconds, so it scales with HOLD_CYCLES
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      snap <= 32'h0;
      hold_cnt <= 32'h0;
    end else if (I_CLK_EN) begin
      if (rd_first) begin
        snap <= live;
        hold_cnt <= HOLD_CYCLES;
      end else begin
        if (!holding) begin
          snap <= live;
        end
        if (holding) begin
          hold_cnt <= hold_cnt - 32'h1;
        end
      end
    end
  end

  // ==========================================
  // interrupt status, set wins over a clear in the same cycle
  assign ev[EV_TICK] = tick_ev;
  assign ev[EV_ALARM] = alarm_ev;
  assign irq_clr = wr_clear ? wd[NUM_EV-1:0] : '0;
  // cause field is the raw status, so it clears with the status bits
  assign cause = {irq_status[EV_ALARM], irq_status[EV_TICK]};

  // one sticky flop per event; a set in the clear cycle is kept, so no event is lost
  generate
    for (genvar i = 0; i < NUM_EV; i++) begin : g_status
      always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
          irq_status[i] <= 1'b0;
        end else if (I_CLK_EN) begin
          irq_status[i] <= ev[i] || (irq_status[i] && !irq_clr[i]);
        end
      end
    end
  endgenerate

  // enable register
  // enable only masks the level; status keeps collecting events
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      irq_enable <= '0;
    end else if (I_CLK_EN && wr_enable) begin
      irq_enable <= wd[NUM_EV-1:0];
    end
  end

  // interrupt level and wake pulse, both registered
  // a tick wakes only when the tick itself is enabled as well
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
      O_WAKE <= 1'b0;
    end else if (I_CLK_EN) begin
      O_IRQ <= |(irq_status & irq_enable);
      O_WAKE <= (tick_ev && tick_wake) || alarm_ev;
    end
  end

  // ==========================================
  // read mux; reserved and unmapped bits read zero
  always_comb begin
    next_rdata = 32'h0;
    if (dph_map) begin
      unique case (dph_idx)
        IDX_WAKE_SEC: next_rdata[7:0] = {cause, w_sec};
        IDX_WAKE_MIN: next_rdata[7:0] = {2'h0, stg_min};
        IDX_WAKE_HOUR: next_rdata[7:0] = {3'h0, stg_hour};
        IDX_WAKE_DAY: next_rdata[7:0] = {3'h0, stg_day};
        IDX_WAKE_MONTH: next_rdata[7:0] = {2'h0, tick_wake, tick_min, stg_mon};
        IDX_WAKE_YEAR: next_rdata[7:0] = {tick_on, alarm_on, act_year};
        IDX_ELAPSED0: next_rdata[7:0] = live[7:0];
        IDX_ELAPSED1: next_rdata[7:0] = snap[15:8];
        IDX_ELAPSED2: next_rdata[7:0] = snap[23:16];
        IDX_ELAPSED3: next_rdata[7:0] = snap[31:24];
        IDX_IRQ_STATUS: next_rdata[NUM_EV-1:0] = irq_status;
        IDX_IRQ_CLEAR: next_rdata = 32'h0; // write-only
        IDX_IRQ_ENABLE: next_rdata[NUM_EV-1:0] = irq_enable;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // read data loaded at the end of the wait cycle
  // it stands until the next read, so a slow master still sees it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_HRDATA <= 32'h0;
    end else if (I_CLK_EN && phase == PH_READ) begin
      O_HRDATA <= next_rdata;
    end
  end

  // ==========================================
  // calendar and event detection
  // the calendar runs from reset only; this block has no time-set path
  // elapsed seconds come from the same counter chain as the calendar
  rat_calendar #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_cal (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CLK_EN),
    .o_sec_stb(sec_stb),
    .o_sec(c_sec),
    .o_min(c_min),
    .o_hour(c_hour),
    .o_day(c_day),
    .o_mon(c_mon),
    .o_year(c_year),
    .o_count(live)
  );

  // events are one-cycle strobes; the status flops above make them sticky
  // the match is checked once per second, on the strobe
  rat_events u_ev (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CLK_EN),
    .i_sec_stb(sec_stb),
    .i_sec(c_sec),
    .i_min(c_min),
    .i_hour(c_hour),
    .i_day(c_day),
    .i_mon(c_mon),
    .i_year(c_year),
    .i_w_sec(w_sec),
    .i_w_min(act_min),
    .i_w_hour(act_hour),
    .i_w_day(act_day),
    .i_w_mon(act_mon),
    .i_w_year(act_year),
    .i_tick_on(tick_on),
    .i_tick_min(tick_min),
    .i_alarm_on(alarm_on),
    .o_tick_ev(tick_ev),
    .o_alarm_ev(alarm_ev)
  );
endmodule // rat_top

// ---- testbench/rat_chk.sv ----
// ==========================================
// bus and event checks at the top ports
module rat_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_CLK_EN,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_IRQ,
  input wire logic O_WAKE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  logic tk;
  logic wr_ph;
  // a transfer is taken only with select, nonseq/seq, ready and enable
  assign tk = I_HSEL & I_HTRANS[1] & I_HREADY & I_CLK_EN;
  // remembers a write data phase, the only thing allowed to drop the interrupt
  always_ff @(posedge I_SYS_CLK) begin
    wr_ph <= I_RST_N & tk & I_HWRITE;
  end
  property p_rd_wait;
    tk && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait cycle wrong");
  property p_wr_nowait;
    tk && I_HWRITE |=> O_HREADYOUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_no_stray;
    !O_HREADYOUT |-> $past(tk && !I_HWRITE);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("wait without read");
  property p_okay;
    O_HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_upper_zero;
    O_HREADYOUT |-> O_HRDATA[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_rdata_hold;
    !$stable(O_HRDATA) |-> !$past(O_HREADYOUT);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_wake_pulse;
    O_WAKE |=> !O_WAKE [*8];
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
  property p_irq_fall;
    $fell(O_IRQ) |-> $past(wr_ph) || $past(wr_ph, 2) || $past(wr_ph, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule // rat_chk

// ---- testbench/testbench.sv ----
module testbench import rat_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic clk_en = 1'b1;
  logic hready, hresp, irq, wake;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  // hold of 16 cycles leaves margin around the prescaler phase guess
  rat_top #(.SEC_CYCLES(SC), .HOLD_CYCLES(16)) u_rat_top (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_IRQ(irq), .O_WAKE(wake));
  initial forever #50 clk = ~clk;
  // cycle count doubles as time base and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      wrap_up();
    end
  end
  // ==========================================
  // bus tasks
  task automatic wrap_up;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b1; haddr <= {22'h0, idx, 2'h0};
    rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    rdy();
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b0; haddr <= {22'h0, idx, 2'h0};
    rdy();
    hsel <= 1'b0; htrans <= 2'h0;
    rdy();
    chk(hrdata, exp);
  endtask
  task automatic cnt_wake(input int n, input int exp);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (wake === 1'b1) k++;
    end
    chk(32'(k), 32'(exp));
  endtask
  task automatic till(input int c);
    while (cyc < c) @(posedge clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_fields;
    logic [7:0] ix [7];
    logic [7:0] ex [7];
    ix = '{IDX_WAKE_SEC, IDX_WAKE_MIN, IDX_WAKE_HOUR, IDX_WAKE_DAY, IDX_WAKE_MONTH, IDX_WAKE_YEAR, 8'h50};
    ex = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) rc(ix[i], {24'h0, ex[i]});
    for (int i = 0; i < 5; i++) wr(ix[i], 32'hffff_ffff);
    wr(IDX_WAKE_YEAR, 32'h3f);
    wr(8'h50, 32'hff);
    ex = '{8'h3f, 8'h3f, 8'h1f, 8'h1f, 8'h3f, 8'h3f, 8'h00};
    for (int i = 0; i < 7; i++) rc(ix[i], {24'h0, ex[i]});
  endtask
  task automatic t_elapsed;
    till(2 + 511 * SC + 11);
    rc(IDX_ELAPSED0, 32'hff);
    till(2 + 512 * SC + 1);
    rc(IDX_ELAPSED1, 32'h01);
    till(2 + 513 * SC + 1);
    wr(IDX_ELAPSED1, 32'h55);
    rc(IDX_ELAPSED1, 32'h02);
    rc(IDX_ELAPSED2, 32'h00);
    rc(IDX_ELAPSED3, 32'h00);
  endtask
  task automatic t_tick;
    wr(IDX_IRQ_ENABLE, 32'h1);
    wr(IDX_WAKE_MONTH, 32'h20);
    wr(IDX_WAKE_YEAR, 32'h80);
    cnt_wake(5 * SC, 5);
    chk(irq, 1'b1);
    rc(IDX_IRQ_STATUS, 32'h1);
    rc(IDX_WAKE_SEC, 32'h7f);
    wr(IDX_WAKE_MONTH, 32'h30);
    cnt_wake(5 * SC, 0);
    cnt_wake(60 * SC, 1);
    wr(IDX_WAKE_MONTH, 32'h00);
    cnt_wake(3 * SC, 0);
    wr(IDX_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(IDX_WAKE_YEAR, 32'h00);
    repeat (5) @(posedge clk);
    wr(IDX_IRQ_CLEAR, 32'h3);
    rc(IDX_IRQ_STATUS, 32'h0);
  endtask
  task automatic t_alarm;
    int s;
    s = (cyc - 2) / SC + 6;
    wr(IDX_IRQ_ENABLE, 32'h2);
    wr(IDX_WAKE_SEC, 32'(s % 60));
    wr(IDX_WAKE_HOUR, 32'h0);
    wr(IDX_WAKE_DAY, 32'h1);
    wr(IDX_WAKE_MONTH, 32'h1);
    wr(IDX_WAKE_MIN, 32'(s / 60 + 1));
    wr(IDX_WAKE_YEAR, 32'h40);
    // right minute only staged, so the match must not happen
    wr(IDX_WAKE_MIN, 32'(s / 60));
    till(2 + (s + 2) * SC);
    chk(irq, 1'b0);
    s = (cyc - 2) / SC + 4;
    wr(IDX_WAKE_SEC, 32'(s % 60));
    wr(IDX_WAKE_MIN, 32'(s / 60));
    wr(IDX_WAKE_YEAR, 32'h40);
    cnt_wake(10 * SC, 1);
    chk(irq, 1'b1);
    rc(IDX_IRQ_STATUS, 32'h2);
    rc(IDX_WAKE_SEC, 32'(8'h80 | (s % 60)));
  endtask
  // clock enable low must freeze the seconds count
  task automatic t_freeze;
    int k;
    k = (cyc - 2) / SC + 2;
    till(2 + k * SC + 2);
    rc(IDX_ELAPSED0, 32'(k % 256));
    clk_en <= 1'b0;
    repeat (3 * SC) @(posedge clk);
    clk_en <= 1'b1;
    rc(IDX_ELAPSED0, 32'(k % 256));
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_fields();
    t_elapsed();
    t_tick();
    t_alarm();
    t_freeze();
    wrap_up();
  end
endmodule // testbench
bind rat_top rat_chk u_rat_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CLK_EN(I_CLK_EN), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
  .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));
